// ===== logic/bus_arb_pkg.sv
// Shared constants and types for the bus arbitration unit and the external master end
package bus_arb_pkg;

	// ==========================================
	// Arbiter states
	typedef enum logic [2:0] {
		ARB_IDLE = 3'h0,
		ARB_DEFER = 3'h1,
		ARB_GRANT = 3'h2,
		ARB_RELEASED = 3'h3,
		ARB_REGRANT_WAIT = 3'h4
	} arb_state_t;

	// ==========================================
	// External master states
	typedef enum logic [1:0] {
		MST_IDLE = 2'h0,
		MST_REQUEST = 2'h1,
		MST_OWN = 2'h2
	} mst_state_t;

	// ==========================================
	// Timing counts
	localparam logic [2:0] REGRANT_DELAY = 3'h2; // Cycles spent in the regrant wait state before granting again
	localparam logic [2:0] CYCLE_STATE_S0 = 3'h0; // Own bus cycle phase before strobe
	localparam int SYNC_WIDTH = 8; // Request, acknowledge, halt, error, transfer, three irq

endpackage

// ===== logic/bus_arb_if.sv
// Arbitration wires shared by the processor end and the external master end
`timescale 1ns/1ps
`default_nettype none
interface bus_arb_if;
	logic busRequestN;
	logic busGrantN;
	logic grantAcknowledgeN;
	logic addressStrobeN;
	logic transferAcknowledgeN;

	modport processor (
		input busRequestN,
		output busGrantN,
		input grantAcknowledgeN,
		input addressStrobeN,
		input transferAcknowledgeN
	);

	modport master (
		output busRequestN,
		input busGrantN,
		output grantAcknowledgeN,
		input addressStrobeN,
		input transferAcknowledgeN
	);
endinterface
`default_nettype wire

// ===== logic/bus_arbiter.sv
// Processor-side bus arbitration unit with falling-then-rising input synchronisers
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Arbitration link
	bus_arb_if.processor link,
	// Other asynchronous processor inputs
	input wire logic resetInN,
	input wire logic haltN,
	input wire logic busErrorN,
	input wire logic [2:0] interruptPriorityLevelN,
	// Core bus sequencer view
	input wire logic cycleCommitted,
	input wire logic strobeIssued,
	input wire logic [2:0] cycleState,
	// Outputs to the core
	output logic threeState,
	output logic cycleAllowed,
	output logic syncResetN,
	output logic syncHaltN,
	output logic syncBusErrorN,
	output logic syncTransferAckN,
	output logic [2:0] syncInterruptN
);

	// ==========================================
	// Synchronisers
	logic [bus_arb_pkg::SYNC_WIDTH-1:0] rawIn;
	logic [bus_arb_pkg::SYNC_WIDTH-1:0] fallStage;
	logic [bus_arb_pkg::SYNC_WIDTH-1:0] syncIn;

	assign rawIn = {interruptPriorityLevelN, link.transferAcknowledgeN, busErrorN, haltN,
		link.grantAcknowledgeN, link.busRequestN};

	// Falling-edge sample of each asynchronous input
	genvar gi;
	generate
		for (gi = 0; gi < bus_arb_pkg::SYNC_WIDTH; gi++) begin : gSync
			always_ff @(negedge ref_clk) begin
				if (!rst_n) begin
					fallStage[gi] <= 1'b1;
				end else if (clkEn) begin
					fallStage[gi] <= rawIn[gi];
				end
			end
			// Usable from the next rising edge
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					syncIn[gi] <= 1'b1;
				end else if (clkEn) begin
					syncIn[gi] <= fallStage[gi];
				end
			end
		end
	endgenerate

	// Reset line uses the same scheme; its falling stage is not reset by rst_n, and its output resets low
	logic resetFall;
	always_ff @(negedge ref_clk) begin
		if (clkEn) begin
			resetFall <= resetInN;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			syncResetN <= 1'b0;
		end else if (clkEn) begin
			syncResetN <= resetFall;
		end
	end

	// ==========================================
	// Decode helpers

	// Turns an active-low pin view into a true-when-asserted flag
	function automatic logic asserted(input logic pinN);
		return ~pinN;
	endfunction

	// Grant is shown only while the grant state is held
	function automatic logic grantState(input bus_arb_pkg::arb_state_t s);
		return s == bus_arb_pkg::ARB_GRANT;
	endfunction

	// Buses float once another master holds or is being handed the bus
	function automatic logic floatState(input bus_arb_pkg::arb_state_t s);
		return (s != bus_arb_pkg::ARB_IDLE) && (s != bus_arb_pkg::ARB_DEFER);
	endfunction

	// Core may start its own cycle only if nobody else is due to take the bus
	function automatic logic coreMayStart(input logic floating, input logic wanted);
		return ~floating & ~wanted;
	endfunction

	// Active-high internal views
	wire logic reqSync = asserted(syncIn[0]); // R, wire-ORed requests
	wire logic ackSync = asserted(syncIn[1]); // A, pulled high in two-wire use

	assign syncHaltN = syncIn[2];
	assign syncBusErrorN = syncIn[3];
	assign syncTransferAckN = syncIn[4];
	assign syncInterruptN = syncIn[7:5];

	// ==========================================
	// Arbitration state machine
	bus_arb_pkg::arb_state_t state;
	bus_arb_pkg::arb_state_t next_state;
	// Counts cycles spent waiting to hand the bus out again
	logic [2:0] waitCount;
	// Remembers that the last edge still saw a held-back cycle
	logic s0Hit;

	// Committed cycle without strobe yet defers the grant
	wire logic holdBack = cycleCommitted & ~strobeIssued & (cycleState == bus_arb_pkg::CYCLE_STATE_S0);

	always_comb begin
		next_state = state;
		case (state)
			// Core owns the bus; a request is granted or deferred
			bus_arb_pkg::ARB_IDLE: begin
				if (reqSync && holdBack) begin
					next_state = bus_arb_pkg::ARB_DEFER;
				end else if (reqSync) begin
					next_state = bus_arb_pkg::ARB_GRANT;
				end
			end
			// Committed cycle has not shown its strobe yet
			bus_arb_pkg::ARB_DEFER: begin
				if (!reqSync) begin
					next_state = bus_arb_pkg::ARB_IDLE;
				end else if (!holdBack && !s0Hit) begin
					// Strobe seen an edge ago: grant on the second edge
					next_state = bus_arb_pkg::ARB_GRANT;
				end
			end
			// Grant shown until acknowledged or request gone
			bus_arb_pkg::ARB_GRANT: begin
				if (ackSync) begin
					next_state = bus_arb_pkg::ARB_RELEASED;
				end else if (!reqSync) begin
					next_state = bus_arb_pkg::ARB_IDLE;
				end
			end
			// Another master holds the bus through its acknowledge
			bus_arb_pkg::ARB_RELEASED: begin
				if (reqSync) begin
					next_state = bus_arb_pkg::ARB_REGRANT_WAIT;
				end else if (!ackSync) begin
					next_state = bus_arb_pkg::ARB_IDLE;
				end
			end
			// Further request pending: pause, then grant again
			bus_arb_pkg::ARB_REGRANT_WAIT: begin
				if (waitCount >= bus_arb_pkg::REGRANT_DELAY) begin
					next_state = bus_arb_pkg::ARB_GRANT;
				end else if (!reqSync) begin
					next_state = bus_arb_pkg::ARB_RELEASED;
				end
			end
			default: begin
				next_state = bus_arb_pkg::ARB_IDLE;
			end
		endcase
	end

	// Grant and float decode of the coming state
	logic next_grant;
	logic next_float;
	logic next_allowed;
	logic grantN;
	assign next_grant = grantState(next_state);
	assign next_float = floatState(next_state);
	// A request not held back stops new core cycles at once
	assign next_allowed = coreMayStart(next_float, reqSync & ~holdBack);

	// ==========================================
	// State register
	// State register and registered outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= bus_arb_pkg::ARB_IDLE;
			grantN <= 1'b1;
			threeState <= 1'b0;
			cycleAllowed <= 1'b1;
			waitCount <= 3'h0;
			s0Hit <= 1'b0;
		end else if (clkEn) begin
			state <= next_state;
			grantN <= ~next_grant;
			threeState <= next_float;
			cycleAllowed <= next_allowed;
			waitCount <= (next_state == bus_arb_pkg::ARB_REGRANT_WAIT) ? waitCount + 3'h1 : 3'h0;
			s0Hit <= holdBack;
		end
	end

	// ==========================================
	// Link output
	// Grant pin comes straight from its flip-flop, so it never glitches
	assign link.busGrantN = grantN;

endmodule
`default_nettype wire

// ===== logic/bus_master.sv
// External bus master end: requests, awaits grant, acknowledges and releases the bus
`timescale 1ns/1ps
`default_nettype none
module bus_master (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Arbitration link
	bus_arb_if.master link,
	// User side
	input wire logic threeWire,
	input wire logic checkTransferAck,
	input wire logic wantBus,
	input wire logic workDone,
	output logic ownsBus
);

	// ==========================================
	// Master state machine
	bus_arb_pkg::mst_state_t state;
	bus_arb_pkg::mst_state_t next_state;
	logic requestReg;
	logic ackReg;

	// Bus free for takeover
	wire logic busQuiet = link.addressStrobeN & link.grantAcknowledgeN &
		(link.transferAcknowledgeN | ~checkTransferAck);

	always_comb begin
		next_state = state;
		case (state)
			bus_arb_pkg::MST_IDLE: begin
				if (wantBus) begin
					next_state = bus_arb_pkg::MST_REQUEST;
				end
			end
			bus_arb_pkg::MST_REQUEST: begin
				if (!link.busGrantN && (!threeWire || busQuiet)) begin
					next_state = bus_arb_pkg::MST_OWN;
				end
			end
			bus_arb_pkg::MST_OWN: begin
				if (workDone) begin
					next_state = bus_arb_pkg::MST_IDLE;
				end
			end
			default: begin
				next_state = bus_arb_pkg::MST_IDLE;
			end
		endcase
	end

	// Request stays up while owning in two-wire mode, drops on the same edge that asserts acknowledge in three-wire
	wire logic next_request = (next_state == bus_arb_pkg::MST_REQUEST) ||
		((next_state == bus_arb_pkg::MST_OWN) && !threeWire);
	wire logic next_ack = (next_state == bus_arb_pkg::MST_OWN) && threeWire;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= bus_arb_pkg::MST_IDLE;
			requestReg <= 1'b0;
			ackReg <= 1'b0;
			ownsBus <= 1'b0;
		end else if (clkEn) begin
			state <= next_state;
			requestReg <= next_request;
			ackReg <= next_ack;
			ownsBus <= (next_state == bus_arb_pkg::MST_OWN);
		end
	end

	assign link.busRequestN = ~requestReg;
	assign link.grantAcknowledgeN = ~ackReg; // Stays high in two-wire use

endmodule
`default_nettype wire

// ===== dv/bus_arb_chk.sv
// Assertions on the arbitration wires
`timescale 1ns/1ps
`default_nettype none
module bus_arb_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Arbitration wires
	input wire logic busRequestN,
	input wire logic busGrantN,
	input wire logic grantAcknowledgeN,
	input wire logic addressStrobeN,
	input wire logic transferAcknowledgeN
);
	// ==========================================
	// Properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_rst;
		$rose(rst_n) |-> busGrantN && busRequestN && grantAcknowledgeN;
	endproperty
	a_rst: assert property (p_rst) else $error("lines active at reset exit");
	property p_cause;
		$fell(busGrantN) |-> !$past(busRequestN);
	endproperty
	a_cause: assert property (p_cause) else $error("grant without request");
	property p_stand;
		!busGrantN && !busRequestN && grantAcknowledgeN |=> !busGrantN;
	endproperty
	a_stand: assert property (p_stand) else $error("grant dropped early");
	property p_twoDrop;
		$rose(busRequestN) && !busGrantN && grantAcknowledgeN |-> ##[1:3] busGrantN;
	endproperty
	a_twoDrop: assert property (p_twoDrop) else $error("grant kept");
	property p_ackDrop;
		$fell(grantAcknowledgeN) |-> ##[1:4] busGrantN;
	endproperty
	a_ackDrop: assert property (p_ackDrop) else $error("grant kept after ack");
	property p_ackAs;
		$fell(grantAcknowledgeN) |-> $past(addressStrobeN);
	endproperty
	a_ackAs: assert property (p_ackAs) else $error("ack during strobe");
	property p_ackGrant;
		$fell(grantAcknowledgeN) |-> !$past(busGrantN);
	endproperty
	a_ackGrant: assert property (p_ackGrant) else $error("ack without grant");
	property p_reqDrop;
		$fell(grantAcknowledgeN) |-> ##[0:2] busRequestN;
	endproperty
	a_reqDrop: assert property (p_reqDrop) else $error("request kept");
	// Main scenarios reached
	c_grant: cover property ($fell(busGrantN));
	c_ack: cover property (!grantAcknowledgeN && transferAcknowledgeN);
	c_two: cover property ($rose(busRequestN) && grantAcknowledgeN);
endmodule
`default_nettype wire

// ===== dv/processor_bus_arbitration_unit_tb.sv
// Bench joining the arbiter and the master end
`timescale 1ns/1ps
`default_nettype none
module processor_bus_arbitration_unit_tb;
	int n_fail = 0, n_compared = 0, i;
	logic [7:0] rnd = 8'h28;
	logic ref_clk = 1'b0, rst_n = 1'b0, threeWire = 1'b1, checkAck = 1'b0, wantBus = 1'b0, workDone = 1'b0;
	logic commit = 1'b0, strobe = 1'b0, resetInN = 1'b1, haltN = 1'b1, busErrorN = 1'b1, clkEn = 1'b1;
	logic [2:0] ipl = 3'h7, cycState = 3'h0, sIpl;
	logic threeState, cycleAllowed, ownsBus, sRst, sHalt, sErr, sAck;
	bus_arb_if link();
	// Clock
	always #2.5 ref_clk = ~ref_clk;
	// Ends and checker
	bus_arbiter i_bus_arbiter (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .link(link.processor),
		.resetInN(resetInN), .haltN(haltN), .busErrorN(busErrorN), .interruptPriorityLevelN(ipl),
		.cycleCommitted(commit), .strobeIssued(strobe), .cycleState(cycState), .threeState(threeState),
		.cycleAllowed(cycleAllowed), .syncResetN(sRst), .syncHaltN(sHalt), .syncBusErrorN(sErr),
		.syncTransferAckN(sAck), .syncInterruptN(sIpl));
	bus_master i_bus_master (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .link(link.master),
		.threeWire(threeWire), .checkTransferAck(checkAck), .wantBus(wantBus), .workDone(workDone),
		.ownsBus(ownsBus));
	bus_arb_chk i_bus_arb_chk (.ref_clk(ref_clk), .rst_n(rst_n), .busRequestN(link.busRequestN),
		.busGrantN(link.busGrantN), .grantAcknowledgeN(link.grantAcknowledgeN),
		.addressStrobeN(link.addressStrobeN), .transferAcknowledgeN(link.transferAcknowledgeN));
	// ==========================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic waitOwn(input logic v);
		for (int k = 0; k < 20 && ownsBus !== v; k++) @(negedge ref_clk);
		check("ownsBus", v, ownsBus);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One ownership round; hold defers the grant behind a committed cycle
	task automatic xfer(input logic tw, input logic hold);
		rnd = lfsr(rnd);
		threeWire <= tw;
		checkAck <= rnd[0];
		commit <= hold;
		cycState <= hold ? bus_arb_pkg::CYCLE_STATE_S0 : rnd[3:1];
		wantBus <= 1'b1;
		if (hold) begin
			repeat (5) @(negedge ref_clk);
			check("busGrantN", 1'b1, link.busGrantN);
			strobe <= 1'b1;
			link.addressStrobeN <= 1'b0;
			repeat (4) @(negedge ref_clk);
			check("busGrantN", 1'b0, link.busGrantN);
			check("grantAcknowledgeN", 1'b1, link.grantAcknowledgeN);
			link.addressStrobeN <= 1'b1;
			commit <= 1'b0;
			strobe <= 1'b0;
		end
		waitOwn(1'b1);
		check("threeState", 1'b1, threeState);
		check("cycleAllowed", 1'b0, cycleAllowed);
		check("busRequestN", tw, link.busRequestN);
		check("grantAcknowledgeN", !tw, link.grantAcknowledgeN);
		wantBus <= 1'b0;
		workDone <= 1'b1;
		@(negedge ref_clk);
		workDone <= 1'b0;
		waitOwn(1'b0);
		repeat (4) @(negedge ref_clk);
		check("threeState", 1'b0, threeState);
		check("busGrantN", 1'b1, link.busGrantN);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		link.addressStrobeN = 1'b1;
		link.transferAcknowledgeN = 1'b1;
		repeat (5) @(negedge ref_clk);
		check("busGrantN", 1'b1, link.busGrantN);
		check("threeState", 1'b0, threeState);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			resetInN <= rnd[6];
			link.transferAcknowledgeN <= rnd[5];
			{haltN, busErrorN, ipl} <= rnd[4:0];
			repeat (2) @(negedge ref_clk);
			check("sync", {rnd[6], rnd[4:3], rnd[5], rnd[2:0]}, {sRst, sHalt, sErr, sAck, sIpl});
		end
		{resetInN, haltN, busErrorN} <= 3'h7;
		link.transferAcknowledgeN <= 1'b1;
		repeat (3) @(negedge ref_clk);
		// Clock enable low freezes both ends
		clkEn <= 1'b0;
		wantBus <= 1'b1;
		repeat (4) @(negedge ref_clk);
		check("busRequestN", 1'b1, link.busRequestN);
		wantBus <= 1'b0;
		clkEn <= 1'b1;
		@(negedge ref_clk);
		for (i = 0; i < 8; i++) begin
			xfer(i[0], i[1]);
		end
		tally_and_finish();
	end
	// Watchdog
	initial begin
		#20000;
		n_fail++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
